/* File: logic/sps_map.svh */
// constant map for the sample pump sequencer
`ifndef SPS_MAP_SVH
`define SPS_MAP_SVH
`define SPS_CLK_PERIOD_NS 100
`define SPS_MAIN_CRYSTAL_HZ 4608000
`define SPS_RELAY_SETTLE_NS 20000
`define SPS_COUNTS_PER_REV 16
`define SPS_PURGE_REVS 4
`define SPS_COMP_SHIFT 2
`define SPS_COUNT_W 16
`define SPS_POS_W 8
`define SPS_STATE_IDLE 4'h0
`define SPS_STATE_SETTLE_REV1 4'h1
`define SPS_STATE_PURGE1 4'h2
`define SPS_STATE_SETTLE_FWD 4'h3
`define SPS_STATE_FILL 4'h4
`define SPS_STATE_DELIVER 4'h5
`define SPS_STATE_SETTLE_REV2 4'h6
`define SPS_STATE_PURGE2 4'h7
`define SPS_STATE_STOP 4'h8
`endif

/* File: logic/sps_pkg.sv */
// types for the sample pump sequencer
`default_nettype none
`include "sps_map.svh"
package sps_pkg;
    typedef enum logic [3:0] {
        SPS_IDLE = `SPS_STATE_IDLE,
        SPS_SETTLE_REV1 = `SPS_STATE_SETTLE_REV1,
        SPS_PURGE1 = `SPS_STATE_PURGE1,
        SPS_SETTLE_FWD = `SPS_STATE_SETTLE_FWD,
        SPS_FILL = `SPS_STATE_FILL,
        SPS_DELIVER = `SPS_STATE_DELIVER,
        SPS_SETTLE_REV2 = `SPS_STATE_SETTLE_REV2,
        SPS_PURGE2 = `SPS_STATE_PURGE2,
        SPS_STOP = `SPS_STATE_STOP
    } sps_state_t;
    // dir_fwd low is reverse: the relay rests in reverse
    typedef struct packed {
        logic dir_fwd;
        logic run;
    } sps_pump_drive_t;
    typedef struct packed {
        logic fwd;
        logic rev;
    } sps_dist_drive_t;
endpackage
`default_nettype wire

/* File: logic/sps_rotor_counter.sv */
// rotor pulse and revolution counter
`timescale 1ns/10ps
`default_nettype none
`include "sps_map.svh"
module sps_rotor_counter #(
    parameter int W = `SPS_COUNT_W,
    parameter int COUNTS_PER_REV = `SPS_COUNTS_PER_REV
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic count_en,
    input wire logic clear,
    input wire logic rotor_pulse,
    output logic [W-1:0] pulse_count,
    output logic [W-1:0] rev_count
);
    logic pulse_d;
    logic next_pulse_d;
    logic [W-1:0] next_pulse_count;
    logic [W-1:0] next_rev_count;

    always_comb begin
        next_pulse_d = rotor_pulse;
        next_pulse_count = pulse_count;
        next_rev_count = rev_count;
        if (clear) begin
            next_pulse_count = '0;
            next_rev_count = '0;
        end else if (count_en && rotor_pulse && !pulse_d) begin
            // a fixed number of counts makes one revolution
            if (pulse_count == W'(COUNTS_PER_REV - 1)) begin
                next_pulse_count = '0;
                next_rev_count = rev_count + W'(1);
            end else begin
                next_pulse_count = pulse_count + W'(1);
            end
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            pulse_d <= 1'b0;
            pulse_count <= '0;
            rev_count <= '0;
        end else begin
            pulse_d <= next_pulse_d;
            pulse_count <= next_pulse_count;
            rev_count <= next_rev_count;
        end
    end
endmodule
`default_nettype wire

/* File: logic/sps_sequencer.sv */
// sample pump sequencer with distributor position tracking
`timescale 1ns/10ps
`default_nettype none
`include "sps_map.svh"
module sps_sequencer #(
    parameter int W = `SPS_COUNT_W,
    parameter int POS_W = `SPS_POS_W,
    parameter int COUNTS_PER_REV = `SPS_COUNTS_PER_REV,
    parameter int SETTLE_CYCLES =
        (`SPS_RELAY_SETTLE_NS + `SPS_CLK_PERIOD_NS - 1) / `SPS_CLK_PERIOD_NS,
    parameter int PURGE_REVS = `SPS_PURGE_REVS,
    parameter int COMP_SHIFT = `SPS_COMP_SHIFT
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic sample_request,
    input wire logic liquid_present,
    input wire logic rotor_pulse,
    input wire logic [W-1:0] volume_revs,
    input wire logic dist_move_fwd,
    input wire logic dist_move_rev,
    input wire logic dist_opto,
    output sps_pkg::sps_pump_drive_t pump_drive,
    output logic busy,
    output logic [W-1:0] fill_revs,
    output sps_pkg::sps_dist_drive_t dist_drive,
    output logic [POS_W-1:0] dist_position
);
    sps_pkg::sps_state_t state;
    sps_pkg::sps_state_t next_state;
    sps_pkg::sps_pump_drive_t next_pump_drive;
    logic next_busy;
    logic [15:0] settle_cnt;
    logic [15:0] next_settle_cnt;
    logic [W-1:0] next_fill_revs;
    logic [W-1:0] target_revs;
    logic [W-1:0] next_target_revs;
    logic [W-1:0] rev_count;
    logic rev_clear;
    sps_pkg::sps_dist_drive_t next_dist_drive;
    logic [POS_W-1:0] next_dist_position;
    logic opto_d;
    logic next_opto_d;

    // every step restarts the revolution count
    assign rev_clear = (next_state != state);

    // sensor pulses only while running, so counting is gated by run
    sps_rotor_counter #(
        .W(W),
        .COUNTS_PER_REV(COUNTS_PER_REV)
    ) u_rotor_counter (
        .ref_clk(ref_clk),
        .reset(reset),
        .count_en(pump_drive.run),
        .clear(rev_clear),
        .rotor_pulse(rotor_pulse),
        .pulse_count(),
        .rev_count(rev_count)
    );

    always_comb begin
        next_state = state;
        next_pump_drive = pump_drive;
        next_settle_cnt = settle_cnt;
        next_fill_revs = fill_revs;
        next_target_revs = target_revs;
        next_busy = 1'b1;
        case (state)
            sps_pkg::SPS_IDLE: begin
                next_busy = 1'b0;
                next_pump_drive.run = 1'b0;
                next_pump_drive.dir_fwd = 1'b0;
                if (sample_request) begin
                    next_state = sps_pkg::SPS_SETTLE_REV1;
                    next_settle_cnt = 16'(SETTLE_CYCLES - 1);
                    next_busy = 1'b1;
                end
            end
            sps_pkg::SPS_SETTLE_REV1: begin
                if (settle_cnt == 16'h0000) begin
                    next_state = sps_pkg::SPS_PURGE1;
                    next_pump_drive.run = 1'b1;
                end else begin
                    next_settle_cnt = settle_cnt - 16'h0001;
                end
            end
            sps_pkg::SPS_PURGE1: begin
                if (rev_count >= W'(PURGE_REVS)) begin
                    // power drops a cycle before the relay moves, so contacts never break current
                    next_pump_drive.run = 1'b0;
                    // one extra count: the settle time runs from the relay change, not from here
                    next_settle_cnt = 16'(SETTLE_CYCLES);
                    next_state = sps_pkg::SPS_SETTLE_FWD;
                end
            end
            sps_pkg::SPS_SETTLE_FWD: begin
                next_pump_drive.dir_fwd = 1'b1;
                if (settle_cnt == 16'h0000) begin
                    next_state = sps_pkg::SPS_FILL;
                    next_pump_drive.run = 1'b1;
                end else begin
                    next_settle_cnt = settle_cnt - 16'h0001;
                end
            end
            sps_pkg::SPS_FILL: begin
                if (liquid_present) begin
                    // longer fill means higher head; extend delivery to suit
                    next_fill_revs = rev_count;
                    next_target_revs = W'(volume_revs + (rev_count >> COMP_SHIFT));
                    next_state = sps_pkg::SPS_DELIVER;
                end
            end
            sps_pkg::SPS_DELIVER: begin
                if (rev_count >= target_revs) begin
                    next_pump_drive.run = 1'b0;
                    next_settle_cnt = 16'(SETTLE_CYCLES);
                    next_state = sps_pkg::SPS_SETTLE_REV2;
                end
            end
            sps_pkg::SPS_SETTLE_REV2: begin
                next_pump_drive.dir_fwd = 1'b0;
                if (settle_cnt == 16'h0000) begin
                    next_state = sps_pkg::SPS_PURGE2;
                    next_pump_drive.run = 1'b1;
                end else begin
                    next_settle_cnt = settle_cnt - 16'h0001;
                end
            end
            sps_pkg::SPS_PURGE2: begin
                if (rev_count >= W'(PURGE_REVS)) begin
                    next_pump_drive.run = 1'b0;
                    next_state = sps_pkg::SPS_STOP;
                end
            end
            sps_pkg::SPS_STOP: begin
                next_state = sps_pkg::SPS_IDLE;
            end
            default: begin
                next_state = sps_pkg::SPS_IDLE;
                next_pump_drive.run = 1'b0;
            end
        endcase
    end

    // ref_clk is the crystal reference that paces the whole sequence
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state <= sps_pkg::SPS_IDLE;
            pump_drive <= '0;
            settle_cnt <= 16'h0000;
            fill_revs <= '0;
            target_revs <= '0;
            busy <= 1'b0;
        end else begin
            state <= next_state;
            pump_drive <= next_pump_drive;
            settle_cnt <= next_settle_cnt;
            fill_revs <= next_fill_revs;
            target_revs <= next_target_revs;
            busy <= next_busy;
        end
    end

    // distributor: forward wins if both moves are asked
    always_comb begin
        next_opto_d = dist_opto;
        next_dist_drive.fwd = dist_move_fwd;
        next_dist_drive.rev = dist_move_rev & ~dist_move_fwd;
        next_dist_position = dist_position;
        if (dist_opto && !opto_d) begin
            if (dist_drive.fwd) begin
                next_dist_position = dist_position + POS_W'(1);
            end else if (dist_drive.rev) begin
                next_dist_position = dist_position - POS_W'(1);
            end
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            opto_d <= 1'b0;
            dist_drive <= '0;
            dist_position <= '0;
        end else begin
            opto_d <= next_opto_d;
            dist_drive <= next_dist_drive;
            dist_position <= next_dist_position;
        end
    end

    // cycles since the last direction change, saturating
    logic [15:0] since_dir;
    logic [15:0] next_since_dir;
    always_comb begin
        next_since_dir = since_dir;
        if (pump_drive.dir_fwd != next_pump_drive.dir_fwd) begin
            next_since_dir = 16'h0000;
        end else if (since_dir != 16'hffff) begin
            next_since_dir = since_dir + 16'h0001;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            since_dir <= 16'h0000;
        end else begin
            since_dir <= next_since_dir;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    AST_START_REVERSE: assert property (
        state == sps_pkg::SPS_IDLE && sample_request |=>
        state == sps_pkg::SPS_SETTLE_REV1 && !pump_drive.dir_fwd && !pump_drive.run)
        else $error("event did not start in reverse with run low");
    AST_FILL_FORWARD: assert property (
        state == sps_pkg::SPS_FILL |-> pump_drive.dir_fwd && pump_drive.run)
        else $error("fill not running forward");
    AST_DELIVER_HOLD: assert property (
        state == sps_pkg::SPS_DELIVER && rev_count < target_revs |=>
        state == sps_pkg::SPS_DELIVER && pump_drive.run && pump_drive.dir_fwd)
        else $error("delivery ended before target");
    AST_PURGE_THEN_OFF: assert property (
        state == sps_pkg::SPS_PURGE2 && rev_count >= W'(PURGE_REVS) |=>
        !pump_drive.run && !pump_drive.dir_fwd ##1 state == sps_pkg::SPS_IDLE)
        else $error("pump not stopped after final purge");
    AST_IDLE_WAIT: assert property (
        state == sps_pkg::SPS_IDLE && !sample_request |=>
        state == sps_pkg::SPS_IDLE && !pump_drive.run && !busy)
        else $error("left idle without request");
    AST_SETTLE_BEFORE_RUN: assert property (
        $rose(pump_drive.run) |-> since_dir >= 16'(SETTLE_CYCLES))
        else $error("run raised before relay settle time");
    AST_DIR_ONLY_UNPOWERED: assert property (
        $changed(pump_drive.dir_fwd) |-> !pump_drive.run && !$past(pump_drive.run))
        else $error("direction changed while powered");
    AST_NO_COUNT_STOPPED: assert property (
        !pump_drive.run && !rev_clear |=> $stable(rev_count))
        else $error("revolutions counted while stopped");
    AST_FILL_CAPTURE: assert property (
        state == sps_pkg::SPS_FILL && liquid_present |=>
        fill_revs == $past(rev_count) && state == sps_pkg::SPS_DELIVER &&
        target_revs == W'($past(volume_revs) + ($past(rev_count) >> COMP_SHIFT)))
        else $error("fill count not used for delivery target");
    AST_DIST_TRACK: assert property (
        dist_opto && !opto_d && dist_drive.fwd |=>
        dist_position == POS_W'($past(dist_position) + POS_W'(1)))
        else $error("distributor position not advanced");
    AST_DIST_EXCLUSIVE: assert property (
        !(dist_drive.fwd && dist_drive.rev))
        else $error("distributor driven both ways");

    COV_FULL_EVENT: cover property (
        state == sps_pkg::SPS_STOP ##1 state == sps_pkg::SPS_IDLE);
    COV_LIQUID: cover property (state == sps_pkg::SPS_FILL && liquid_present);
    COV_DIST_REV: cover property (dist_opto && !opto_d && dist_drive.rev);
    COV_BACK_TO_BACK: cover property (
        state == sps_pkg::SPS_IDLE && sample_request && $past(state == sps_pkg::SPS_STOP));
endmodule
`default_nettype wire

/* File: tb/sps_pump_model.sv */
// pump relay driver and rotor sensor model for the sequencer bench
`timescale 1ns/10ps
`default_nettype none
module sps_pump_model #(
    parameter int HALF = 2
) (
    input wire logic ref_clk,
    input wire sps_pkg::sps_pump_drive_t pump_drive,
    output logic rotor_pulse,
    output logic relay_fwd
);
    int cnt = 0;
    // relay at rest selects reverse, so dir_fwd low means reverse pumping
    assign relay_fwd = pump_drive.dir_fwd;
    // sensor unpowered outside a run: the line sits low and never pulses
    always @(posedge ref_clk) begin
        if (pump_drive.run !== 1'b1) begin
            cnt <= 0;
            rotor_pulse <= 1'b0;
        end else if (cnt == HALF - 1) begin
            cnt <= 0;
            rotor_pulse <= ~rotor_pulse;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule
`default_nettype wire

/* File: tb/sps_sequencer_tb_top.sv */
// self-checking bench for the sample pump sequencer
`timescale 1ns/10ps
`default_nettype none
module sps_sequencer_tb_top;
    localparam int CPR = 2;
    localparam int SETTLE = 3;
    typedef struct {
        logic [15:0] vol;
        int fill;
        logic [15:0] efill;
        int edel;
    } sps_row_t;
    sps_row_t rows [3] = '{'{16'h0002, 4, 16'h0004, 6}, '{16'h0001, 1, 16'h0001, 2},
        '{16'h0003, 8, 16'h0008, 10}};
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic sample_request = 1'b0;
    logic liquid_present = 1'b0;
    logic rotor_pulse;
    logic [15:0] volume_revs = 16'h0000;
    logic dist_move_fwd = 1'b0;
    logic dist_move_rev = 1'b0;
    logic dist_opto = 1'b0;
    sps_pkg::sps_pump_drive_t pump_drive;
    logic busy;
    logic [15:0] fill_revs;
    sps_pkg::sps_dist_drive_t dist_drive;
    logic [7:0] dist_position;
    int num_errors = 0;
    int n_compared = 0;
    int i;
    always #50 ref_clk = ~ref_clk;
    sps_sequencer #(.COUNTS_PER_REV(CPR), .SETTLE_CYCLES(SETTLE), .PURGE_REVS(1)) u_sps_sequencer (
        .ref_clk(ref_clk), .reset(reset), .sample_request(sample_request),
        .liquid_present(liquid_present), .rotor_pulse(rotor_pulse), .volume_revs(volume_revs),
        .dist_move_fwd(dist_move_fwd), .dist_move_rev(dist_move_rev), .dist_opto(dist_opto),
        .pump_drive(pump_drive), .busy(busy), .fill_revs(fill_revs), .dist_drive(dist_drive),
        .dist_position(dist_position));
    sps_pump_model #(.HALF(2)) u_sps_pump_model (
        .ref_clk(ref_clk), .pump_drive(pump_drive), .rotor_pulse(rotor_pulse), .relay_fwd());
    task automatic chk(input bit ok, input string msg);
        n_compared++;
        if (!ok) begin
            num_errors++;
            $display("MISMATCH at %0t: %s", $time, msg);
        end
    endtask
    task automatic give_verdict;
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // one run segment: settle gap, direction, rotor pulses; lift raises liquid mid-run
    task automatic seg(input logic edir, input int epulses, input int lift, input bit exact);
        int gap;
        int np;
        int k;
        bit bad;
        logic prev;
        gap = 0;
        np = 0;
        bad = 0;
        for (k = 0; k < 2000 && pump_drive.run !== 1'b1; k++) begin
            gap = (pump_drive.dir_fwd === edir) ? gap + 1 : 0;
            @(negedge ref_clk);
        end
        chk(exact ? gap == SETTLE : gap >= SETTLE, "relay settle gap");
        chk(pump_drive.dir_fwd === edir, "pump direction");
        prev = rotor_pulse;
        for (k = 0; k < 2000 && pump_drive.run === 1'b1; k++) begin
            // liquid rises a cycle after the last fill pulse, once that pulse is counted
            if (lift > 0 && np == lift) liquid_present = 1'b1;
            if (rotor_pulse === 1'b1 && prev === 1'b0) np++;
            prev = rotor_pulse;
            if (pump_drive.dir_fwd !== edir || busy !== 1'b1) bad = 1;
            @(negedge ref_clk);
        end
        liquid_present = 1'b0;
        chk(!bad, "direction or busy moved while running");
        chk(np == epulses, "rotor pulses in segment");
    endtask
    task automatic opto(input int n);
        repeat (n) begin
            dist_opto = 1'b1;
            @(negedge ref_clk);
            dist_opto = 1'b0;
            @(negedge ref_clk);
        end
        @(negedge ref_clk);
    endtask
    initial begin
        repeat (30000) @(posedge ref_clk);
        num_errors++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        give_verdict();
    end
    initial begin
        repeat (4) @(negedge ref_clk);
        chk(pump_drive === 2'b00 && busy === 1'b0 && fill_revs === 16'h0000, "reset outputs");
        reset = 1'b0;
        $display("test reset done");
        // request held high: each event restarts from the first step once idle
        sample_request = 1'b1;
        for (i = 0; i < 3; i++) begin
            volume_revs = rows[i].vol;
            seg(1'b0, CPR, 0, 1'b0);
            if (i == 2) sample_request = 1'b0;
            seg(1'b1, rows[i].fill * CPR + rows[i].edel, rows[i].fill * CPR, 1'b1);
            chk(fill_revs === rows[i].efill, "fill revolutions");
            seg(1'b0, CPR, 0, 1'b1);
            $display("test event %0d done", i);
        end
        for (i = 0; i < 10 && busy !== 1'b0; i++) @(negedge ref_clk);
        chk(busy === 1'b0, "busy after stop");
        repeat (50) begin
            @(negedge ref_clk);
            if (pump_drive.run !== 1'b0 || busy !== 1'b0) i = 99;
        end
        chk(i != 99, "idle without request");
        $display("test idle done");
        sample_request = 1'b1;
        repeat (12) @(negedge ref_clk);
        sample_request = 1'b0;
        reset = 1'b1;
        #1;
        chk(pump_drive === 2'b00 && busy === 1'b0, "reset mid event");
        repeat (2) @(negedge ref_clk);
        reset = 1'b0;
        $display("test mid reset done");
        dist_move_fwd = 1'b1;
        repeat (2) @(negedge ref_clk);
        opto(3);
        chk(dist_drive.fwd === 1'b1 && dist_drive.rev === 1'b0, "distributor forward");
        chk(dist_position === 8'h03, "position after forward");
        dist_move_rev = 1'b1;
        repeat (2) @(negedge ref_clk);
        opto(1);
        chk(dist_position === 8'h04, "both requests move forward");
        dist_move_fwd = 1'b0;
        repeat (2) @(negedge ref_clk);
        opto(2);
        chk(dist_drive.rev === 1'b1 && dist_position === 8'h02, "distributor reverse");
        $display("test distributor done");
        give_verdict();
    end
endmodule
`default_nettype wire
